// file: hw/fll_clock_mode_control.sv
// mode and loop filter control for the locked-loop clock generator
// assumes apb on pclk; clock condition flags arrive synchronous to pclk
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/10ps
module fll_clock_mode_control
  import fll_mode_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // trim keeps its value over system reset; power-on only
  input wire logic por_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // power mode
  input wire logic stop_req,
  input wire logic wake_irq,
  input wire logic background_debug,
  // loop conditions
  input wire logic err_in_unlock,
  input wire logic err_in_lock,
  input wire logic osc_running,
  input wire logic ext_ref_ok_flag,
  input wire logic clock_loss_flag,
  input wire logic crystal_used,
  input wire logic ref_tick,
  // oscillator control
  output logic [11:0] loop_filter_value,
  output logic [7:0] reference_period_trim,
  output logic [2:0] multiplier_select,
  output logic loop_closed,
  output logic use_ext_ref,
  output logic osc_enable,
  output logic gen_out_enable,
  output logic gen_out_div2,
  output logic sys_feed_enable
);
  import fll_mode_pkg::*;

  mode_type mode_q, mode_d;
  logic [11:0] filter_q;
  logic [7:0] trim_q;
  logic [1:0] sel_q;
  logic [2:0] mult_q;
  logic stopen_q;
  logic [1:0] latch_q;
  logic [1:0] stat_sync_q [sync_stages];
  logic stable_q;
  logic err_prev_q;
  logic locked_q;
  logic ever_locked_q;
  logic div2_q;
  logic [12:0] xcnt_q;
  logic xtal_done;
  logic feed_q;
  logic off_active;
  logic wr, rd;
  logic [1:0] mode_code;

  function automatic logic [1:0] code_of(input mode_type m);
    case (m)
      st_int: code_of = sel_int;
      st_byp: code_of = sel_byp;
      st_ext: code_of = sel_ext;
      default: code_of = sel_self;
    endcase
  endfunction : code_of

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign mode_code = code_of(mode_q);
  assign xtal_done = !crystal_used || xcnt_q[12];

  // register writes; trim reset only at power-on
  // trim output on power-on reset too, so a system reset cannot move it
  always_ff @(posedge pclk or negedge por_n)
  begin
    if (!por_n)
    begin
      trim_q <= trim_reset;
      reference_period_trim <= trim_reset;
    end
    else
    begin
      if (wr && paddr == addr_trim)
        trim_q <= pwdata[7:0];
      reference_period_trim <= trim_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel_q <= sel_reset;
      mult_q <= mult_reset;
      stopen_q <= 1'b0;
    end
    else if (wr && paddr == addr_control)
    begin
      sel_q <= pwdata[ctl_sel_lsb +: 2];
      mult_q <= pwdata[ctl_mult_lsb +: 3];
      stopen_q <= pwdata[ctl_stopen_bit];
    end
    else if (mode_q inside {st_ext, st_byp} && !ext_ref_ok_flag && clock_loss_flag)
      sel_q <= sel_self;
  end

  // filter: lower written into staging, upper write latches all twelve bits
  logic [7:0] lower_stage_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      filter_q <= filter_reset;
      lower_stage_q <= filter_reset[7:0];
      latch_q <= 2'h0;
    end
    else
    begin
      if (latch_q != 2'h0)
        latch_q <= latch_q - 2'h1;
      if (wr && sel_q == sel_self && paddr == addr_filter_lower)
        lower_stage_q <= pwdata[7:0];
      if (wr && sel_q == sel_self && paddr == addr_filter_upper && latch_q == 2'h0)
      begin
        filter_q <= {pwdata[3:0], lower_stage_q};
        latch_q <= latch_cycles;
      end
    end
  end

  // stable flag: two consecutive samples within unlock window
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stable_q <= 1'b0;
      err_prev_q <= 1'b0;
    end
    else if (mode_q == st_off)
    begin
      stable_q <= 1'b0;
      err_prev_q <= 1'b0;
    end
    else
    begin
      err_prev_q <= err_in_unlock;
      stable_q <= err_prev_q && err_in_unlock && osc_running;
    end
  end

  // lock tracking inside the locked modes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      locked_q <= 1'b0;
      ever_locked_q <= 1'b0;
    end
    else if (!(mode_q inside {st_int, st_ext}))
    begin
      locked_q <= 1'b0;
      ever_locked_q <= 1'b0;
    end
    else if (locked_q && !err_in_unlock)
      locked_q <= 1'b0;
    else if (!locked_q && err_in_lock)
    begin
      locked_q <= 1'b1;
      ever_locked_q <= 1'b1;
    end
  end

  // crystal start count on reference ticks
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      xcnt_q <= 13'h0000;
    else if (!ext_ref_ok_flag || mode_q == st_off)
      xcnt_q <= 13'h0000;
    else if (ref_tick && !xcnt_q[12])
      xcnt_q <= xcnt_q + 13'h0001;
  end

  // stop handling: debug keeps all running, osc enable gates feed only
  assign off_active = stop_req && !background_debug && !stopen_q;

  always_comb
  begin
    mode_d = mode_q;
    unique case (mode_q)
      st_off:
        if (!stop_req || wake_irq)
          mode_d = (sel_q == sel_byp) ? st_byp : (sel_q[0] ? st_wait : st_self);
      st_wait:
        if (off_active)
          mode_d = st_off;
        else if (sel_q == sel_self)
          mode_d = st_self;
        else if (stable_q)
          mode_d = (sel_q == sel_int) ? st_int : st_ext;
      st_self, st_int, st_ext, st_byp:
        if (off_active)
          mode_d = st_off;
        else if (sel_q == sel_self)
          mode_d = st_self;
        else if (sel_q == sel_int)
          mode_d = st_int;
        else if (sel_q == sel_ext && mode_q != st_ext)
          mode_d = (ext_ref_ok_flag && stable_q) ? st_ext : mode_q;
        else if (sel_q == sel_byp && mode_q != st_byp && ext_ref_ok_flag)
          mode_d = st_byp;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_q <= st_self;
    else
      mode_q <= mode_d;
  end

  // output halving: only in external locked mode until its first lock
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div2_q <= 1'b0;
    else if (mode_q == st_ext && mode_d == st_self && !locked_q)
      div2_q <= 1'b0;
    else if (mode_q == st_ext)
      div2_q <= !locked_q && !ever_locked_q;
    else
      div2_q <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      feed_q <= 1'b1;
    else
      feed_q <= !stop_req || background_debug;
  end

  // mode status resync, as across clock domains
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      for (int i = 0; i < sync_stages; i++)
        stat_sync_q[i] <= sel_self;
    else
    begin
      stat_sync_q[0] <= mode_code;
      for (int i = 1; i < sync_stages; i++)
        stat_sync_q[i] <= stat_sync_q[i-1];
    end
  end

  // read mux, registered data held across the access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (rd)
    begin
      unique case (paddr)
        addr_filter_upper: prdata <= {28'h0000000, filter_q[11:8]};
        addr_filter_lower: prdata <= {24'h000000, filter_q[7:0]};
        addr_trim: prdata <= {24'h000000, trim_q};
        addr_control: prdata <= {26'h0000000, stopen_q, mult_q, sel_q};
        addr_status: prdata <= {24'h000000, mode_q == st_off, sys_feed_enable,
          gen_out_div2, gen_out_enable, locked_q, stable_q, stat_sync_q[sync_stages-1]};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // oscillator side outputs; divider R is outside and used alike
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      loop_filter_value <= filter_reset;
      multiplier_select <= mult_reset;
      loop_closed <= 1'b0;
      use_ext_ref <= 1'b0;
      osc_enable <= 1'b1;
      gen_out_enable <= 1'b1;
      gen_out_div2 <= 1'b0;
      sys_feed_enable <= 1'b1;
    end
    else
    begin
      loop_filter_value <= filter_q;
      multiplier_select <= mult_q;
      loop_closed <= mode_q inside {st_int, st_ext};
      use_ext_ref <= (mode_q == st_ext && xtal_done) || (mode_q == st_byp);
      osc_enable <= mode_q != st_off && mode_q != st_byp;
      gen_out_enable <= mode_q != st_off &&
        !(mode_q == st_byp && !(ext_ref_ok_flag && xtal_done));
      gen_out_div2 <= div2_q;
      sys_feed_enable <= feed_q && mode_q != st_off;
    end
  end

  a_filter_lock: assert property (@(posedge pclk) disable iff (!presetn)
    (sel_q != sel_self) |=> $stable(filter_q) || $past(sel_q) == sel_self)
    else $error("filter changed outside self clocked");
  a_latch_busy: assert property (@(posedge pclk) disable iff (!presetn)
    (latch_q != 2'h0) |=> $stable(filter_q))
    else $error("filter changed while latch busy");
  a_upper_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == addr_filter_upper && sel_q == sel_self && latch_q == 2'h0)
    |=> filter_q[11:8] == $past(pwdata[3:0]) ##2 loop_filter_value == filter_q)
    else $error("upper write did not latch");
  a_stop_off: assert property (@(posedge pclk) disable iff (!presetn)
    (off_active && mode_q != st_off && mode_q != st_wait) |=> mode_q == st_off)
    else $error("stop did not enter off");
  a_debug_run: assert property (@(posedge pclk) disable iff (!presetn)
    (background_debug && mode_q != st_off) |=> mode_q != st_off)
    else $error("debug stop halted clocks");
  a_stable_off: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_q == st_off) |=> !stable_q)
    else $error("stable flag set in off");
  a_wait_lock: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_q == st_wait && stable_q && sel_q == sel_int && !off_active) |=> mode_q == st_int)
    else $error("no switch to locked after stable");
  a_status_sync: assert property (@(posedge pclk) disable iff (!presetn)
    ##2 stat_sync_q[sync_stages-1] == $past(mode_code, 2))
    else $error("mode status not resynced");
  a_loop_open: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_q == st_self) |=> !loop_closed)
    else $error("loop closed in self clocked");
  a_fallback: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_q == st_ext && !ext_ref_ok_flag && clock_loss_flag && !off_active)
    |=> ##1 mode_q == st_self)
    else $error("no fallback on lost reference");
  a_bypass_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_q == st_byp && !xtal_done) |=> !gen_out_enable)
    else $error("bypass output enabled before stable");
endmodule : fll_clock_mode_control

// file: inc/fll_mode_pkg.sv
// constants and types for the clock mode and filter control block
// shared by the design and the bench; no timescale in a package
package fll_mode_pkg;
  // register byte addresses on apb
  localparam logic [7:0] addr_filter_upper = 8'h00;
  localparam logic [7:0] addr_filter_lower = 8'h04;
  localparam logic [7:0] addr_trim = 8'h08;
  localparam logic [7:0] addr_control = 8'h0C;
  localparam logic [7:0] addr_status = 8'h10;
  // control register fields
  localparam int ctl_sel_lsb = 0;
  localparam int ctl_mult_lsb = 2;
  localparam int ctl_stopen_bit = 5;
  // status register fields
  localparam int st_mode_lsb = 0;
  localparam int st_stable_bit = 2;
  localparam int st_lock_bit = 3;
  localparam int st_out_en_bit = 4;
  localparam int st_div2_bit = 5;
  localparam int st_feed_bit = 6;
  localparam int st_off_bit = 7;
  // reset values
  localparam logic [11:0] filter_reset = 12'h800;
  localparam logic [7:0] trim_reset = 8'h80;
  localparam logic [1:0] sel_reset = 2'h0;
  localparam logic [2:0] mult_reset = 3'h0;
  // clock select and mode status encodings
  localparam logic [1:0] sel_self = 2'h0;
  localparam logic [1:0] sel_int = 2'h1;
  localparam logic [1:0] sel_byp = 2'h2;
  localparam logic [1:0] sel_ext = 2'h3;
  // filter latch sequence length in cycles
  localparam logic [1:0] latch_cycles = 2'h2;
  // mode status resync depth
  localparam int sync_stages = 2;
  // crystal start count, in reference clocks
  localparam int xtal_count = 4096;
  typedef enum logic [2:0] {st_self, st_int, st_byp, st_ext, st_off, st_wait} mode_type;
endpackage : fll_mode_pkg

// file: verification/ext_clock_source.sv
// behavioural external clock source seen from the pclk side
// assumes the bench switches the source in and out through present
`timescale 1ns/10ps
module ext_clock_source (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // source fitted and oscillating
  input wire logic present,
  // conditions handed to the block
  output logic ref_tick,
  output logic ext_ref_ok_flag,
  output logic clock_loss_flag
);
  logic [1:0] div_q;
  // reference runs at a quarter of pclk; ticks stop dead when absent
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_q <= 2'h0;
      ref_tick <= 1'b0;
    end
    else
    begin
      div_q <= div_q + 2'h1;
      ref_tick <= present && (div_q == 2'h3);
    end
  end
  // loss is sticky until reset, as the real monitor would keep it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_ref_ok_flag <= 1'b0;
      clock_loss_flag <= 1'b0;
    end
    else
    begin
      ext_ref_ok_flag <= present;
      clock_loss_flag <= clock_loss_flag | (ext_ref_ok_flag & ~present);
    end
  end
endmodule : ext_clock_source

// file: verification/fll_clock_mode_control_tb.sv
// self-checking bench for the clock mode and filter control block
// assumes apb answers with pready; external source is a behavioural model
`timescale 1ns/10ps
module fll_clock_mode_control_tb;
  import fll_mode_pkg::*;
  logic pclk, pready, pslverr, ext_ref_ok_flag, clock_loss_flag, ref_tick, loop_closed;
  logic use_ext_ref, osc_enable, gen_out_enable, gen_out_div2, sys_feed_enable;
  logic presetn = 1'b0, por_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic stop_req = 1'b0, wake_irq = 1'b0, background_debug = 1'b0, crystal_used = 1'b0;
  logic err_in_unlock = 1'b1, err_in_lock = 1'b1, osc_running = 1'b1, present = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic [7:0] reference_period_trim;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic [11:0] loop_filter_value;
  logic [2:0] multiplier_select;
  int fail_count = 0, samples_checked = 0, cycles = 0;

  fll_clock_mode_control uut (.pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .stop_req(stop_req), .wake_irq(wake_irq),
    .background_debug(background_debug), .err_in_unlock(err_in_unlock),
    .err_in_lock(err_in_lock), .osc_running(osc_running), .ext_ref_ok_flag(ext_ref_ok_flag),
    .clock_loss_flag(clock_loss_flag), .crystal_used(crystal_used), .ref_tick(ref_tick),
    .loop_filter_value(loop_filter_value), .reference_period_trim(reference_period_trim),
    .multiplier_select(multiplier_select), .loop_closed(loop_closed),
    .use_ext_ref(use_ext_ref), .osc_enable(osc_enable), .gen_out_enable(gen_out_enable),
    .gen_out_div2(gen_out_div2), .sys_feed_enable(sys_feed_enable));
  ext_clock_source src (.pclk(pclk), .presetn(presetn), .present(present),
    .ref_tick(ref_tick), .ext_ref_ok_flag(ext_ref_ok_flag), .clock_loss_flag(clock_loss_flag));

  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // hang guard; the crystal start count takes most of the run
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fail_count++;
      summarize();
    end
  end

  task summarize;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize
  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    if (got !== exp)
      fail_count++;
  endtask : chk_word
  task chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask : chk_bit
  task idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle
  // more keeps the select up so the next setup follows at once
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic more);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    if (!more)
    begin
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask : wr
  task rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 1'b0);
    chk_word(rd, exp);
  endtask : rchk

  task t_reset;
    idle(4);
    rchk(addr_filter_upper, {28'h0, filter_reset[11:8]});
    rchk(addr_filter_lower, {24'h0, filter_reset[7:0]});
    rchk(addr_control, 32'h0);
    rchk(addr_status, 32'h54);
    chk_word(loop_filter_value, filter_reset);
    $display("reset test done");
  endtask : t_reset
  task t_filter;
    wr(addr_filter_lower, 32'h34);
    apb(1'b1, addr_filter_upper, 32'h5, 1'b1);
    apb(1'b1, addr_filter_upper, 32'h9, 1'b0);
    idle(2);
    chk_word(loop_filter_value, 12'h534);
    rchk(addr_filter_lower, 32'h34);
    wr(addr_filter_upper, 32'hA);
    idle(2);
    chk_word(loop_filter_value, 12'hA34);
    $display("filter test done");
  endtask : t_filter
  task t_modes;
    wr(addr_control, 32'h0D);
    idle(4);
    apb(1'b0, addr_status, 32'h0, 1'b0);
    chk_word(rd[1:0], sel_int);
    chk_bit(loop_closed, 1'b1);
    chk_word(multiplier_select, 3'h3);
    wr(addr_filter_upper, 32'h2);
    idle(2);
    chk_word(loop_filter_value, 12'hA34);
    stop_req <= 1'b1;
    idle(3);
    stop_req <= 1'b0;
    idle(2);
    chk_bit(loop_closed, 1'b0);
    idle(4);
    chk_bit(loop_closed, 1'b1);
    wr(addr_control, 32'h0C);
    idle(4);
    apb(1'b0, addr_status, 32'h0, 1'b0);
    chk_word(rd[1:0], sel_self);
    chk_bit(loop_closed, 1'b0);
    $display("mode test done");
  endtask : t_modes
  task t_stop;
    stop_req <= 1'b1;
    idle(3);
    chk_bit(sys_feed_enable, 1'b0);
    chk_bit(osc_enable, 1'b0);
    chk_bit(gen_out_enable, 1'b0);
    apb(1'b0, addr_status, 32'h0, 1'b0);
    chk_bit(rd[st_off_bit], 1'b1);
    chk_bit(rd[st_stable_bit], 1'b0);
    stop_req <= 1'b0;
    wake_irq <= 1'b1;
    idle(1);
    wake_irq <= 1'b0;
    idle(3);
    chk_bit(sys_feed_enable, 1'b1);
    rchk(addr_control, 32'h0C);
    background_debug <= 1'b1;
    stop_req <= 1'b1;
    idle(3);
    chk_bit(sys_feed_enable, 1'b1);
    chk_bit(osc_enable, 1'b1);
    stop_req <= 1'b0;
    background_debug <= 1'b0;
    wr(addr_control, 32'h2C);
    stop_req <= 1'b1;
    idle(3);
    chk_bit(osc_enable, 1'b1);
    chk_bit(sys_feed_enable, 1'b0);
    stop_req <= 1'b0;
    idle(3);
    chk_bit(sys_feed_enable, 1'b1);
    $display("stop test done");
  endtask : t_stop
  task t_loss;
    crystal_used <= 1'b1;
    err_in_lock <= 1'b0;
    wr(addr_control, 32'h03);
    idle(4);
    chk_bit(use_ext_ref, 1'b0);
    chk_bit(gen_out_div2, 1'b1);
    idle(16400);
    chk_bit(use_ext_ref, 1'b1);
    present <= 1'b0;
    idle(6);
    apb(1'b0, addr_control, 32'h0, 1'b0);
    chk_word(rd[1:0], sel_self);
    idle(2);
    apb(1'b0, addr_status, 32'h0, 1'b0);
    chk_word(rd[1:0], sel_self);
    chk_bit(gen_out_div2, 1'b0);
    present <= 1'b1;
    err_in_lock <= 1'b1;
    $display("loss test done");
  endtask : t_loss
  task t_trim;
    wr(addr_trim, 32'h3C);
    presetn <= 1'b0;
    idle(3);
    chk_word(reference_period_trim, 8'h3C);
    presetn <= 1'b1;
    idle(2);
    rchk(addr_trim, 32'h3C);
    chk_word(reference_period_trim, 8'h3C);
    rchk(addr_control, 32'h0);
    chk_word(loop_filter_value, filter_reset);
    wr(addr_control, 32'h02);
    idle(4);
    chk_bit(gen_out_enable, 1'b0);
    crystal_used <= 1'b0;
    idle(3);
    chk_bit(gen_out_enable, 1'b1);
    $display("trim test done");
  endtask : t_trim

  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_filter();
    t_modes();
    t_stop();
    t_loss();
    t_trim();
    summarize();
  end
endmodule : fll_clock_mode_control_tb
